/* src/lpcs_pkg.sv */
package lpcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the two-wire control port
  localparam logic [7:0] ADDR_CP_MID = 8'h12;
  localparam logic [7:0] ADDR_CP_TOP = 8'h13;
  localparam logic [7:0] ADDR_THR = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h15;
  localparam logic [7:0] ADDR_DP = 8'h16;
  localparam logic [7:0] ADDR_FLAGS = 8'h17;
  localparam logic [7:0] ADDR_CNT_LO = 8'h18;
  localparam logic [7:0] ADDR_CNT_HI = 8'h19;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ALIGN_DONE_BIT = 7;
  localparam int CNT_CLEAR_BIT = 4;
  localparam int FLAG_CLEAR_BIT = 3;
  localparam int DP_EN_LSB = 4;
  localparam int LANES = 4;
  localparam int CNT_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // reset and limit values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [2:0] RST_3 = 3'h0;
  localparam logic [11:0] CNT_MAX = 12'hfff;

  ////////////////////////////////////////////////////////////////////////////
  // datapath check selector codes; 101..111 reserved
  typedef enum logic [2:0] {
    DP_DISPARITY = 3'h0,
    DP_BUF_ALL = 3'h1,
    DP_BUF_OVF = 3'h2,
    DP_BUF_UNF = 3'h3,
    DP_ALIGN = 3'h4
  } lpcs_dp_sel_type;

  // test flag source codes; other codes give quiet flags, except flag 0, which carries dp_hit while datapath checking runs
  typedef enum logic [2:0] {
    FS_MISMATCH = 3'h0,
    FS_DATAPATH = 3'h1,
    FS_ALIGN = 3'h2
  } lpcs_flag_src_type;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpcs_reg_req_type;

  typedef struct packed {
    logic [3:0] mismatch;
    logic [3:0] disparity;
    logic [3:0] buf_ovf;
    logic [3:0] buf_unf;
  } lpcs_lane_evt_type;

endpackage

/* src/lpcs_top.sv */
`timescale 1ns/1ps

module lpcs_top
  import lpcs_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire lpcs_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic link_clk,
  input wire lpcs_lane_evt_type lane_evt,
  input wire logic lane_align_done,
  input wire logic pattern_len_twenty,
  input wire logic [7:0] custom_pattern_low,
  input wire logic [3:0] verifier_load,
  output logic [3:0][19:0] lane_pattern,
  output logic [3:0][2:0] lane_threshold,
  output logic [3:0] test_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for link side levels; a third stage on the
  // link clock finds its rising edge
  logic [17:0] sync1_ff, sync2_ff;
  logic lclk_prev_ff;
  logic [17:0] nxt_sync1, nxt_sync2;
  logic nxt_lclk_prev;

  always_comb begin
    nxt_sync1 = {link_clk, lane_align_done, lane_evt};
    nxt_sync2 = sync1_ff;
    nxt_lclk_prev = sync2_ff[17];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      lclk_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      lclk_prev_ff <= nxt_lclk_prev;
    end
  end

  logic lclk_rise;
  logic align_s;
  lpcs_lane_evt_type evt_s;
  assign lclk_rise = sync2_ff[17] & ~lclk_prev_ff;
  assign align_s = sync2_ff[16];
  assign evt_s = sync2_ff[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] cp_mid_ff, nxt_cp_mid;
  logic [3:0] cp_top_ff, nxt_cp_top;
  logic [2:0] thr_ff, nxt_thr;
  logic [2:0] flag_src_ff, nxt_flag_src;
  logic [3:0] dp_en_ff, nxt_dp_en;
  logic [2:0] dp_sel_ff, nxt_dp_sel;
  logic cnt_clr_ff, nxt_cnt_clr;
  logic flag_clr_ff, nxt_flag_clr;
  logic wr_hit;

  always_comb begin
    nxt_cp_mid = cp_mid_ff;
    nxt_cp_top = cp_top_ff;
    nxt_thr = thr_ff;
    nxt_flag_src = flag_src_ff;
    nxt_dp_en = dp_en_ff;
    nxt_dp_sel = dp_sel_ff;
    // self-clearing: each written one is a fresh rising edge
    nxt_cnt_clr = 1'b0;
    nxt_flag_clr = 1'b0;
    wr_hit = reg_req.wr;
    if (wr_hit) begin
      case (reg_req.addr)
        ADDR_CP_MID: nxt_cp_mid = reg_req.wdata;
        ADDR_CP_TOP: nxt_cp_top = reg_req.wdata[3:0];
        ADDR_THR: nxt_thr = reg_req.wdata[2:0];
        ADDR_CTRL: begin
          nxt_cnt_clr = reg_req.wdata[CNT_CLEAR_BIT];
          nxt_flag_clr = reg_req.wdata[FLAG_CLEAR_BIT];
          nxt_flag_src = reg_req.wdata[2:0];
        end
        ADDR_DP: begin
          nxt_dp_en = reg_req.wdata[DP_EN_LSB +: LANES];
          nxt_dp_sel = reg_req.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cp_mid_ff <= RST_BYTE;
      cp_top_ff <= RST_NIB;
      thr_ff <= RST_3;
      flag_src_ff <= RST_3;
      dp_en_ff <= RST_NIB;
      dp_sel_ff <= RST_3;
      cnt_clr_ff <= 1'b0;
      flag_clr_ff <= 1'b0;
    end else begin
      cp_mid_ff <= nxt_cp_mid;
      cp_top_ff <= nxt_cp_top;
      thr_ff <= nxt_thr;
      flag_src_ff <= nxt_flag_src;
      dp_en_ff <= nxt_dp_en;
      dp_sel_ff <= nxt_dp_sel;
      cnt_clr_ff <= nxt_cnt_clr;
      flag_clr_ff <= nxt_flag_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event selection, live and sticky flags, counter of lane 0 mismatches or of dp_hit while datapath checking runs
  logic [3:0] dp_lane;
  logic [3:0] dp_masked;
  logic dp_active;
  logic dp_hit;
  logic [3:0] live_src;
  logic cnt_inc;
  logic [3:0] live_ff, nxt_live;
  logic [3:0] sticky_ff, nxt_sticky;
  logic [11:0] cnt_ff, nxt_cnt;

  always_comb begin
    case (lpcs_dp_sel_type'(dp_sel_ff))
      DP_DISPARITY: dp_lane = evt_s.disparity;
      DP_BUF_ALL: dp_lane = evt_s.buf_ovf | evt_s.buf_unf;
      DP_BUF_OVF: dp_lane = evt_s.buf_ovf;
      DP_BUF_UNF: dp_lane = evt_s.buf_unf;
      DP_ALIGN: dp_lane = {LANES{~align_s}};
      default: dp_lane = RST_NIB;
    endcase
    dp_masked = dp_lane & dp_en_ff;
    dp_active = |dp_en_ff;
    dp_hit = |dp_masked;
    case (lpcs_flag_src_type'(flag_src_ff))
      FS_MISMATCH: live_src = evt_s.mismatch;
      FS_DATAPATH: live_src = dp_masked;
      FS_ALIGN: live_src = {LANES{align_s}};
      default: live_src = RST_NIB;
    endcase
    if (dp_active) begin
      live_src[0] = dp_hit;
    end
    // link events only count on a sampled link clock edge
    nxt_live = lclk_rise ? live_src : live_ff;
    // a flag raised in the clearing cycle survives the clear
    nxt_sticky = (flag_clr_ff ? RST_NIB : sticky_ff) | live_ff;
    // lane 0 mismatches are not counted while datapath checking runs; the counter counts dp_hit instead
    cnt_inc = lclk_rise & (dp_active ? dp_hit : evt_s.mismatch[0]);
    nxt_cnt = cnt_clr_ff ? 12'h000 : cnt_ff;
    if (cnt_inc && nxt_cnt != CNT_MAX) begin
      nxt_cnt = nxt_cnt + 12'h001; // saturates rather than wraps
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      live_ff <= RST_NIB;
      sticky_ff <= RST_NIB;
      cnt_ff <= 12'h000;
    end else begin
      live_ff <= nxt_live;
      sticky_ff <= nxt_sticky;
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-lane verifier settings, reloaded on every mclk edge while load is high
  logic [19:0] pattern_word;
  assign pattern_word = {pattern_len_twenty ? cp_top_ff : RST_NIB,
                         cp_mid_ff, custom_pattern_low};

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl = gl + 1) begin : g_lane
      logic [19:0] pat_ff, nxt_pat;
      logic [2:0] lthr_ff, nxt_lthr;
      always_comb begin
        nxt_pat = verifier_load[gl] ? pattern_word : pat_ff;
        nxt_lthr = verifier_load[gl] ? thr_ff : lthr_ff;
      end
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          pat_ff <= 20'h00000;
          lthr_ff <= RST_3;
        end else begin
          pat_ff <= nxt_pat;
          lthr_ff <= nxt_lthr;
        end
      end
      assign lane_pattern[gl] = pat_ff;
      assign lane_threshold[gl] = lthr_ff;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped offsets read zero
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  always_comb begin
    nxt_rvalid = reg_req.rd;
    nxt_rdata = rdata_ff;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CP_MID: nxt_rdata = cp_mid_ff;
        ADDR_CP_TOP: nxt_rdata = {RST_NIB, cp_top_ff};
        ADDR_THR: nxt_rdata = {5'h00, thr_ff};
        ADDR_CTRL: nxt_rdata = {align_s, 2'h0, cnt_clr_ff, flag_clr_ff, flag_src_ff};
        ADDR_DP: nxt_rdata = {dp_en_ff, 1'b0, dp_sel_ff};
        ADDR_FLAGS: nxt_rdata = {sticky_ff, live_ff};
        ADDR_CNT_LO: nxt_rdata = cnt_ff[7:0];
        ADDR_CNT_HI: nxt_rdata = {RST_NIB, cnt_ff[11:8]};
        default: nxt_rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= RST_BYTE;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign test_flag = live_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_wr_mid;
    reg_req.wr && reg_req.addr == ADDR_CP_MID;
  endsequence

  sequence s_rd_at(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  sequence s_load_dropped;
    verifier_load[0] ##1 !verifier_load[0];
  endsequence

  a_mid_write: assert property (
    s_wr_mid |=> cp_mid_ff == $past(reg_req.wdata)
  ) else $error("pattern mid byte not stored");

  a_top_masked: assert property (
    verifier_load[0] && !pattern_len_twenty |=> lane_pattern[0][19:16] == 4'h0
  ) else $error("top pattern bits used in sixteen-bit mode");

  a_thr_read: assert property (
    s_rd_at(ADDR_THR) |=> rdata_ff == {5'h00, $past(thr_ff)} && rvalid_ff
  ) else $error("threshold readback wrong");

  a_align_read: assert property (
    s_rd_at(ADDR_CTRL) |=> rdata_ff[7] == $past(align_s)
  ) else $error("alignment done bit wrong");

  a_count_clear: assert property (
    reg_req.wr && reg_req.addr == ADDR_CTRL && reg_req.wdata[CNT_CLEAR_BIT] |=> ##1 cnt_ff <= 12'h001
  ) else $error("count not cleared");

  a_sticky_clear: assert property (
    flag_clr_ff && live_ff == 4'h0 |=> sticky_ff == 4'h0
  ) else $error("sticky flags not cleared");

  a_dp_route: assert property (
    lclk_rise && dp_active |=> live_ff[0] == $past(dp_hit)
  ) else $error("datapath event not on flag 0");

  a_sticky_hold: assert property (
    live_ff != 4'h0 |=> (sticky_ff & $past(live_ff)) == $past(live_ff)
  ) else $error("sticky flag missed a live flag");

  a_load_hold: assert property (
    s_load_dropped ##0 !verifier_load[0] |=> $stable(lane_pattern[0])
  ) else $error("lane settings moved while load low");

  a_count_sat: assert property (
    cnt_ff == CNT_MAX && !cnt_clr_ff |=> cnt_ff == CNT_MAX
  ) else $error("count wrapped");

  a_cnt_ignore: assert property (
    dp_active && !dp_hit && !cnt_clr_ff |=> $stable(cnt_ff)
  ) else $error("pattern mismatch counted during datapath check");

  a_live_hold: assert property (
    !lclk_rise |=> $stable(live_ff)
  ) else $error("live flags moved between link edges");

  a_flags_read: assert property (
    s_rd_at(ADDR_FLAGS) |=> rdata_ff == {$past(sticky_ff), $past(live_ff)}
  ) else $error("status byte readback wrong");

  a_cnt_read: assert property (
    s_rd_at(ADDR_CNT_LO) |=> rdata_ff == $past(cnt_ff[7:0])
  ) else $error("count low byte readback wrong");

  a_align_src: assert property (
    lclk_rise && !dp_active && flag_src_ff == FS_ALIGN |=> live_ff == {LANES{$past(align_s)}}
  ) else $error("alignment source not on live flags");

  a_load_pass: assert property (
    verifier_load[0] |=> lane_pattern[0] == $past(pattern_word)
  ) else $error("lane settings not passed while load high");

  a_top_used: assert property (
    verifier_load[0] && pattern_len_twenty |=> lane_pattern[0][19:16] == $past(cp_top_ff)
  ) else $error("top pattern bits lost in twenty-bit mode");

endmodule

/* dv/lpcs_src_model.sv */
`timescale 1ns/1ps
// video source side: the link clock runs only inside frames
module lpcs_src_model
  import lpcs_pkg::*;
(
  output logic link_clk,
  output lpcs_lane_evt_type lane_evt
);
  initial begin
    link_clk = 1'b0;
    lane_evt = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one event sample per period, stable around the rising edge
  task automatic frame(input lpcs_lane_evt_type e, input int n);
    for (int i = 0; i < n; i++) begin
      lane_evt = e;
      #400 link_clk = 1'b1;
      #400 link_clk = 1'b0;
    end
    // released lines show the inverse, so a stale level never looks valid
    lane_evt = ~e;
  endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb
  import lpcs_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  lpcs_reg_req_type reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic link_clk;
  lpcs_lane_evt_type lane_evt;
  logic lane_align_done = 1'b0;
  logic pattern_len_twenty = 1'b0;
  logic [7:0] custom_pattern_low = 8'h00;
  logic [3:0] verifier_load = 4'h0;
  logic [3:0][19:0] lane_pattern;
  logic [3:0][2:0] lane_threshold;
  logic [3:0] test_flag;
  logic [7:0] exp_q[$];
  int errors = 0;
  int checks = 0;
  logic [31:0] rnd = 32'h8bd50202;
  logic [7:0] mid, top, thr, sel;
  lpcs_lane_evt_type e;

  always #50 mclk = ~mclk;

  lpcs_top DUT (.mclk(mclk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .link_clk(link_clk), .lane_evt(lane_evt),
    .lane_align_done(lane_align_done), .pattern_len_twenty(pattern_len_twenty),
    .custom_pattern_low(custom_pattern_low), .verifier_load(verifier_load),
    .lane_pattern(lane_pattern), .lane_threshold(lane_threshold), .test_flag(test_flag));

  lpcs_src_model source (.link_clk(link_clk), .lane_evt(lane_evt));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [19:0] x, input logic [19:0] got);
    checks++;
    if (got !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, x, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one idle cycle between strobes, so no signal is assigned twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge mclk);
    exp_q.push_back(x);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    reg_req <= '0;
  endtask

  task automatic load_lanes();
    @(negedge mclk);
    verifier_load <= 4'hf;
    @(negedge mclk);
    verifier_load <= 4'h0;
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read monitor: oldest note against each answer
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      checks++;
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected reg_rvalid expected 0 seen 1");
      end else begin
        if (reg_rdata !== exp_q[0]) begin
          errors++;
          $display("unexpected reg_rdata expected %h seen %h", exp_q[0], reg_rdata);
        end
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #6000000;
    errors++;
    $display("unexpected run time expected done seen hang");
    give_verdict();
  end

  initial begin
    idle(8);
    resetn <= 1'b1;
    idle(4);
    for (int a = 8'h12; a <= 8'h1a; a++) begin
      rd(8'(a), 8'h00);
    end
    rd(8'h30, 8'h00);
    $display("test reset values done");
    rnd = lfsr(rnd);
    mid = rnd[7:0];
    top = rnd[15:8];
    thr = rnd[23:16];
    sel = rnd[31:24];
    wr(ADDR_CP_MID, mid);
    wr(ADDR_CP_TOP, top);
    wr(ADDR_THR, thr);
    wr(ADDR_CTRL, {5'h00, sel[2:0]});
    wr(ADDR_DP, thr);
    wr(ADDR_FLAGS, 8'hff);
    lane_align_done <= 1'b1;
    idle(4);
    rd(ADDR_CP_MID, mid);
    rd(ADDR_CP_TOP, {4'h0, top[3:0]});
    rd(ADDR_THR, {5'h00, thr[2:0]});
    rd(ADDR_CTRL, {1'b1, 4'h0, sel[2:0]});
    rd(ADDR_DP, thr & 8'hf7);
    rd(ADDR_FLAGS, 8'h00);
    $display("test register access done");
    custom_pattern_low <= sel;
    for (int m = 0; m < 2; m++) begin
      pattern_len_twenty <= m[0];
      load_lanes();
      for (int n = 0; n < LANES; n++) begin
        chk("lane_pattern", {(m == 1) ? top[3:0] : 4'h0, mid, sel}, lane_pattern[n]);
        chk("lane_threshold", {17'h0, thr[2:0]}, {17'h0, lane_threshold[n]});
      end
    end
    wr(ADDR_CP_MID, ~mid);
    pattern_len_twenty <= 1'b0;
    idle(2);
    chk("lane_pattern", {top[3:0], mid, sel}, lane_pattern[2]);
    $display("test lane load done");
    // mismatch source; 258 samples carry the count into the high nibble
    wr(ADDR_DP, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    e = '0;
    e.mismatch = 4'h5;
    source.frame(e, 258);
    idle(8);
    chk("test_flag", 20'h5, {16'h0, test_flag});
    rd(ADDR_FLAGS, 8'h55);
    rd(ADDR_CNT_LO, 8'h02);
    rd(ADDR_CNT_HI, 8'h01);
    source.frame('0, 1);
    idle(8);
    rd(ADDR_FLAGS, 8'h50);
    wr(ADDR_CTRL, 8'h08);
    idle(2);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    idle(2);
    rd(ADDR_CNT_LO, 8'h00);
    rd(ADDR_CNT_HI, 8'h00);
    // a long frame drives the counter to its ceiling, where it must stop
    source.frame(e, 4100);
    idle(8);
    rd(ADDR_CNT_LO, 8'hff);
    rd(ADDR_CNT_HI, 8'h0f);
    // quiet edge so no live flag leaks into the next clear
    source.frame('0, 1);
    $display("test flags and counter done");
    // datapath codes on lanes 0 and 1; mismatches arrive in a frame of their own
    for (int c = 0; c < 5; c++) begin
      e = '0;
      case (c)
        0: e.disparity = 4'h1;
        1, 3: e.buf_unf = 4'h1;
        2: e.buf_ovf = 4'h1;
        default: e.disparity = 4'hf;
      endcase
      wr(ADDR_DP, {4'h3, 1'b0, 3'(c)});
      wr(ADDR_CTRL, 8'h19);
      idle(2);
      source.frame(e, 1);
      e = '0;
      e.mismatch = 4'hf;
      source.frame(e, 1);
      idle(8);
      rd(ADDR_CNT_LO, (c < 4) ? 8'h01 : 8'h00);
      rd(ADDR_FLAGS, (c < 4) ? 8'h10 : 8'h00);
    end
    $display("test datapath codes done");
    // alignment done as the flag source, datapath checking off
    wr(ADDR_DP, 8'h00);
    wr(ADDR_CTRL, 8'h1a);
    source.frame('0, 1);
    idle(8);
    chk("test_flag", 20'hf, {16'h0, test_flag});
    rd(ADDR_FLAGS, 8'hff);
    $display("test alignment flag source done");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
      idle(1);
    end
    if (exp_q.size() > 0) begin
      errors++;
      $display("unexpected pending reads expected 0 seen %0d", exp_q.size());
    end
    give_verdict();
  end
endmodule
